/* verilog/tlpt_pkg.sv */
/*
 * Shared constants for the two-level page translation unit: entry field
 * positions, register selects, cycle kinds, walk states and reset values.
 * Assumes a single clock domain and word-aligned 32-bit table entries.
 */
// Behaviour
// - translate linear address via directory, then table, then 4 Kbyte frame
// - on page fault store full 32-bit linear address in fault register
// - directory base keeps its low 12 address bits zero, page aligned
// - every load of the directory base flushes all cached translations
// - linear bits 31..22 index the 1024-entry page directory
// - bits 21..12 index the table; frame joins linear bits 11..0
// - entry with present clear is unused and its other bits ignored
// - set accessed bit 5 in directory and table entries before access
// - set dirty bit 6 in table entry before a write; not in directory
// - flag updates use a bus-locked read-modify-write cycle
// - entry bits 9 to 11 are never interpreted nor altered
// - entry bit 2 is user/supervisor, bit 1 is writable
// - privilege level 3 is user; levels 0, 1, 2 are supervisor
// - write-protect set: supervisor write to read-only page faults
// - user access to supervisor page or user read-only write faults
// - rights are the more restrictive of directory and table flags
// - write-through flag exported on pin, unused by on-chip cache
// - cache-disable flag forbids caching whatever enable input or controls
// - paging off or non-memory cycles drive both cache pins low
// - paged memory cycles drive cache pins from cached table entry flags
// - walk reads use base register attributes, then directory entry's
// - base register cache bits reset zero, written only at level 0
// - absent directory or table entry raises page fault
// - fault code gives present, write and user bits of the access
package tlpt_pkg;

    // entry fields
    localparam int ENT_PRESENT = 0;
    localparam int ENT_WRITE   = 1;
    localparam int ENT_USER    = 2;
    localparam int ENT_WTHRU   = 3;
    localparam int ENT_NOCACHE = 4;
    localparam int ENT_ACC     = 5;
    localparam int ENT_DIRTY   = 6;
    localparam int BASE_LSB    = 12;

    // fault code fields
    localparam int CODE_PRESENT = 0;
    localparam int CODE_WRITE   = 1;
    localparam int CODE_USER    = 2;

    // register selects and reset values
    localparam logic       SEL_FAULT     = 1'h0;
    localparam logic       SEL_DIRBASE   = 1'h1;
    localparam logic [31:0] DIRBASE_RESET = 32'h0000_0000;
    localparam logic [31:0] FAULT_RESET   = 32'h0000_0000;
    localparam logic [31:0] BASE_KEEP     = 32'hFFFF_F018;
    localparam logic [1:0]  CPL_USER      = 2'h3;
    localparam logic [1:0]  CPL_TOP       = 2'h0;

    // cycle kinds
    localparam logic [1:0] KIND_MEM    = 2'h0;
    localparam logic [1:0] KIND_IO     = 2'h1;
    localparam logic [1:0] KIND_INTACK = 2'h2;
    localparam logic [1:0] KIND_HALT   = 2'h3;

    // translation cache geometry
    localparam int TLB_IDX_W = 3;
    localparam int TLB_DEPTH = 8;
    localparam int TLB_W     = 45;

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_LOOKUP  = 4'h1,
        S_DIR_RD  = 4'h2,
        S_DIR_LRD = 4'h3,
        S_DIR_WR  = 4'h4,
        S_TBL_RD  = 4'h5,
        S_TBL_LRD = 4'h6,
        S_TBL_WR  = 4'h7,
        S_FILL    = 4'h8,
        S_RESP    = 4'h9
    } tlpt_state_type;

endpackage

/* verilog/tlpt_tlb_mem.sv */
/*
 * Small storage array for cached translations; registered read data.
 * Assumes the caller keeps the valid bits, so flush is instantaneous.
 */
`timescale 1ns/10ps
module tlpt_tlb_mem
(
    // clock
    input  wire logic                          mclk,
    // write port
    input  wire logic                          wr_en,
    input  wire logic [tlpt_pkg::TLB_IDX_W-1:0] wr_addr,
    input  wire logic [tlpt_pkg::TLB_W-1:0]     wr_data,
    // read port
    input  wire logic [tlpt_pkg::TLB_IDX_W-1:0] rd_addr,
    output logic      [tlpt_pkg::TLB_W-1:0]     rd_data
);
    import tlpt_pkg::*;

    logic [TLB_W-1:0] store_q [TLB_DEPTH];

    always_ff @(posedge mclk)
    begin
        if (wr_en)
        begin
            store_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk)
    begin
        rd_data <= store_q[rd_addr];
    end

endmodule

/* verilog/tlpt_unit.sv */
/*
 * Two-level page translation unit: translation cache, table walker with
 * locked flag updates, protection checks, fault register, cache pins.
 * Assumes memory answers on mem_ack in the same clock domain and that
 * the requester waits on req_ready.
 */
`timescale 1ns/10ps
module tlpt_unit
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // control register moves
    input  wire logic        reg_wr_en,
    input  wire logic        reg_sel,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [1:0]  reg_cpl,
    output logic      [31:0] fault_address_reg,
    output logic      [31:0] directory_base_reg,
    // machine controls
    input  wire logic        translation_on,
    input  wire logic        write_protect,
    input  wire logic        global_cache_off,
    input  wire logic        external_cache_enable_in_n,
    // translation request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [31:0] req_lin_addr,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_cpl,
    input  wire logic [1:0]  req_kind,
    // translation answer
    output logic             resp_valid,
    output logic [31:0]      resp_phys_addr,
    output logic             resp_fault,
    output logic [2:0]       resp_fault_code,
    output logic             resp_cacheable,
    output logic             cache_disable_flag,
    output logic             write_through_flag,
    // table memory bus
    output logic             mem_req,
    output logic             mem_write,
    output logic             mem_lock,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_nocache,
    output logic             mem_wthru,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata
);
    import tlpt_pkg::*;

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [31:0] entry_addr(input logic [19:0] base,
                                               input logic [9:0]  idx);
        entry_addr = {base, idx, 2'h0};
    endfunction

    function automatic logic prot_fault(input logic us, input logic rw,
                                        input logic user, input logic wr,
                                        input logic wp);
        if (user)
        begin
            prot_fault = !us || (wr && !rw);
        end
        else
        begin
            prot_fault = wr && wp && !rw;
        end
    endfunction

    // =========================================================
    // state
    // =========================================================
    tlpt_state_type          state_q;
    tlpt_state_type          state_d;
    logic [31:0]             lin_q;
    logic                    write_q;
    logic                    user_q;
    logic [31:0]             pde_q;
    logic [31:0]             pde_d;
    logic [31:0]             pte_q;
    logic [31:0]             pte_d;
    logic [TLB_DEPTH-1:0]    valid_q;
    logic [TLB_W-1:0]        tlb_rdata;
    logic [TLB_W-1:0]        tlb_wdata;
    logic [TLB_IDX_W-1:0]    tlb_rd_idx;
    logic                    ce_meta_q;
    logic                    ce_n_q;
    logic                    base_load;
    logic                    hit;
    logic                    need_dirty;
    logic                    us_eff;
    logic                    rw_eff;
    logic                    tbl_prot;
    logic [31:0]             res_phys;
    logic                    res_fault;
    logic                    res_present;
    logic                    res_nocache;
    logic                    res_wthru;
    logic [31:0]             addr_d;
    logic [31:0]             wdata_d;
    logic                    mnocache_d;
    logic                    mwthru_d;

    assign req_ready  = state_q == S_IDLE;
    assign resp_valid = state_q == S_RESP;
    assign mem_req    = state_q inside {S_DIR_RD, S_DIR_LRD, S_DIR_WR,
                                        S_TBL_RD, S_TBL_LRD, S_TBL_WR};
    assign mem_write  = state_q inside {S_DIR_WR, S_TBL_WR};
    assign mem_lock   = state_q inside {S_DIR_LRD, S_DIR_WR,
                                        S_TBL_LRD, S_TBL_WR};
    assign base_load  = reg_wr_en && reg_sel == SEL_DIRBASE
                        && reg_cpl == CPL_TOP;

    // =========================================================
    // translation cache
    // =========================================================
    assign tlb_rd_idx = req_lin_addr[BASE_LSB +: TLB_IDX_W];
    assign hit = valid_q[lin_q[BASE_LSB +: TLB_IDX_W]]
                 && tlb_rdata[44:25] == lin_q[31:12];
    // cached dirty only counts for writes
    assign need_dirty = write_q && !tlb_rdata[0];
    assign us_eff = pde_q[ENT_USER] && mem_rdata[ENT_USER];
    assign rw_eff = pde_q[ENT_WRITE] && mem_rdata[ENT_WRITE];
    assign tbl_prot = prot_fault(us_eff, rw_eff, user_q, write_q,
                                 write_protect);
    assign tlb_wdata = {lin_q[31:12], pte_q[31:12],
                        pde_q[ENT_USER] && pte_q[ENT_USER],
                        pde_q[ENT_WRITE] && pte_q[ENT_WRITE],
                        pte_q[ENT_NOCACHE], pte_q[ENT_WTHRU],
                        pte_q[ENT_DIRTY]};

    tlpt_tlb_mem u_tlb
    (
        .mclk    (mclk),
        .wr_en   (state_q == S_FILL),
        .wr_addr (lin_q[BASE_LSB +: TLB_IDX_W]),
        .wr_data (tlb_wdata),
        .rd_addr (tlb_rd_idx),
        .rd_data (tlb_rdata)
    );

    always_ff @(posedge mclk)
    begin
        if (reset || base_load)
        begin
            valid_q <= '0;
        end
        else if (state_q == S_FILL)
        begin
            valid_q[lin_q[BASE_LSB +: TLB_IDX_W]] <= 1'h1;
        end
    end

    // =========================================================
    // walk sequencing
    // =========================================================
    always_comb
    begin
        state_d     = state_q;
        pde_d       = pde_q;
        pte_d       = pte_q;
        res_phys    = lin_q;
        res_fault   = 1'h0;
        res_present = 1'h0;
        res_nocache = 1'h0;
        res_wthru   = 1'h0;
        case (state_q)
            S_IDLE:
            begin
                if (req_valid)
                begin
                    // no paging means identity and zero pins
                    if (!translation_on || req_kind != KIND_MEM)
                    begin
                        state_d  = S_RESP;
                        res_phys = req_lin_addr;
                    end
                    else
                    begin
                        state_d = S_LOOKUP;
                    end
                end
            end
            S_LOOKUP:
            begin
                if (hit && !need_dirty)
                begin
                    state_d     = S_RESP;
                    res_phys    = {tlb_rdata[24:5], lin_q[11:0]};
                    res_nocache = tlb_rdata[2];
                    res_wthru   = tlb_rdata[1];
                    res_present = 1'h1;
                    res_fault   = prot_fault(tlb_rdata[4], tlb_rdata[3],
                                             user_q, write_q,
                                             write_protect);
                end
                else
                begin
                    state_d = S_DIR_RD;
                end
            end
            S_DIR_RD, S_DIR_LRD:
            begin
                if (mem_ack)
                begin
                    pde_d = mem_rdata;
                    if (!mem_rdata[ENT_PRESENT])
                    begin
                        state_d   = S_RESP;
                        res_fault = 1'h1;
                    end
                    else if (state_q == S_DIR_LRD)
                    begin
                        state_d = S_DIR_WR;
                    end
                    else if (!mem_rdata[ENT_ACC])
                    begin
                        state_d = S_DIR_LRD;
                    end
                    else
                    begin
                        state_d = S_TBL_RD;
                    end
                end
            end
            S_DIR_WR:
            begin
                if (mem_ack)
                begin
                    state_d = S_TBL_RD;
                end
            end
            S_TBL_RD, S_TBL_LRD:
            begin
                if (mem_ack)
                begin
                    pte_d = mem_rdata;
                    if (!mem_rdata[ENT_PRESENT])
                    begin
                        state_d   = S_RESP;
                        res_fault = 1'h1;
                    end
                    else if (tbl_prot)
                    begin
                        state_d     = S_RESP;
                        res_fault   = 1'h1;
                        res_present = 1'h1;
                    end
                    else if (state_q == S_TBL_LRD)
                    begin
                        pte_d[ENT_ACC]   = 1'h1;
                        pte_d[ENT_DIRTY] = mem_rdata[ENT_DIRTY]
                                           || write_q;
                        state_d          = S_TBL_WR;
                    end
                    else if (!mem_rdata[ENT_ACC]
                             || (write_q && !mem_rdata[ENT_DIRTY]))
                    begin
                        state_d = S_TBL_LRD;
                    end
                    else
                    begin
                        state_d = S_FILL;
                    end
                end
            end
            S_TBL_WR:
            begin
                if (mem_ack)
                begin
                    state_d = S_FILL;
                end
            end
            S_FILL:
            begin
                state_d     = S_RESP;
                res_phys    = {pte_q[31:12], lin_q[11:0]};
                res_nocache = pte_q[ENT_NOCACHE];
                res_wthru   = pte_q[ENT_WTHRU];
                res_present = 1'h1;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    // bus address and attributes for the next walk step
    always_comb
    begin
        addr_d  = '0;
        wdata_d = '0;
        mnocache_d = 1'h0;
        mwthru_d   = 1'h0;
        if (state_d inside {S_DIR_RD, S_DIR_LRD, S_DIR_WR})
        begin
            addr_d  = entry_addr(directory_base_reg[31:12],
                                 lin_q[31:22]);
            wdata_d = pde_d | (32'h1 << ENT_ACC);
            mnocache_d = directory_base_reg[ENT_NOCACHE];
            mwthru_d   = directory_base_reg[ENT_WTHRU];
        end
        else if (state_d inside {S_TBL_RD, S_TBL_LRD, S_TBL_WR})
        begin
            addr_d  = entry_addr(pde_d[31:12], lin_q[21:12]);
            wdata_d = pte_d;
            mnocache_d = pde_d[ENT_NOCACHE];
            mwthru_d   = pde_d[ENT_WTHRU];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_q <= S_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lin_q   <= '0;
            write_q <= 1'h0;
            user_q  <= 1'h0;
            pde_q   <= '0;
            pte_q   <= '0;
        end
        else
        begin
            if (state_q == S_IDLE && req_valid)
            begin
                lin_q   <= req_lin_addr;
                write_q <= req_write;
                user_q  <= req_cpl == CPL_USER;
            end
            pde_q <= pde_d;
            pte_q <= pte_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mem_addr  <= '0;
            mem_wdata <= '0;
            mem_nocache <= 1'h0;
            mem_wthru   <= 1'h0;
        end
        else
        begin
            mem_addr  <= addr_d;
            mem_wdata <= wdata_d;
            mem_nocache <= mnocache_d;
            mem_wthru   <= mwthru_d;
        end
    end

    // =========================================================
    // answer and cache pins
    // =========================================================
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ce_meta_q <= 1'h1;
            ce_n_q    <= 1'h1;
        end
        else
        begin
            ce_meta_q <= external_cache_enable_in_n;
            ce_n_q    <= ce_meta_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            resp_phys_addr     <= '0;
            resp_fault         <= 1'h0;
            resp_fault_code    <= '0;
            resp_cacheable     <= 1'h0;
            cache_disable_flag <= 1'h0;
            write_through_flag <= 1'h0;
        end
        else if (state_d == S_RESP && state_q != S_RESP)
        begin
            resp_phys_addr                <= res_phys;
            resp_fault                    <= res_fault;
            resp_fault_code[CODE_PRESENT] <= res_present;
            resp_fault_code[CODE_WRITE]   <= write_q;
            resp_fault_code[CODE_USER]    <= user_q;
            if (state_q == S_IDLE)
            begin
                resp_fault_code[CODE_WRITE] <= req_write;
                resp_fault_code[CODE_USER]  <= req_cpl == CPL_USER;
            end
            resp_cacheable     <= !res_nocache && !ce_n_q
                                  && !global_cache_off;
            cache_disable_flag <= res_nocache;
            write_through_flag <= res_wthru;
        end
    end

    // =========================================================
    // control registers
    // =========================================================
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            directory_base_reg <= DIRBASE_RESET;
        end
        else if (base_load)
        begin
            directory_base_reg <= reg_wdata & BASE_KEEP;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            fault_address_reg <= FAULT_RESET;
        end
        else if (resp_valid && resp_fault)
        begin
            fault_address_reg <= lin_q;
        end
        else if (reg_wr_en && reg_sel == SEL_FAULT)
        begin
            fault_address_reg <= reg_wdata;
        end
    end

    // =========================================================
    // checks
    // =========================================================
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    sequence locked_read_s;
        state_q == S_DIR_LRD && mem_ack && mem_rdata[ENT_PRESENT];
    endsequence

    sequence locked_write_s;
        mem_lock && mem_write && mem_wdata[ENT_ACC];
    endsequence

    flush_on_load_a : assert property (
        base_load |=> valid_q == '0)
        else $error("translation cache not flushed on base load");

    base_aligned_a : assert property (
        (directory_base_reg & ~BASE_KEEP) == '0)
        else $error("directory base low bits not zero");

    fault_capture_a : assert property (
        resp_valid && resp_fault |=> fault_address_reg == $past(lin_q))
        else $error("fault address not captured");

    write_locked_a : assert property (
        mem_req && mem_write |-> mem_lock)
        else $error("flag write outside locked cycle");

    dir_rmw_a : assert property (
        locked_read_s |=> locked_write_s)
        else $error("directory accessed update missing");

    dirty_on_write_a : assert property (
        state_q == S_TBL_WR && write_q |-> mem_wdata[ENT_DIRTY])
        else $error("dirty bit not set for write");

    bypass_pins_a : assert property (
        state_q == S_IDLE && req_valid
        && (!translation_on || req_kind != KIND_MEM)
        |=> resp_valid && !cache_disable_flag && !write_through_flag)
        else $error("cache pins not low when paging bypassed");

    dir_attr_a : assert property (
        state_q == S_DIR_RD |-> mem_nocache == directory_base_reg[ENT_NOCACHE])
        else $error("directory read attribute wrong");

    absent_fault_a : assert property (
        state_q == S_DIR_RD && mem_ack && !mem_rdata[ENT_PRESENT]
        |=> resp_valid && resp_fault && !resp_fault_code[CODE_PRESENT])
        else $error("absent directory entry did not fault");

endmodule

/* test/tlpt_mem_model.sv */
/*
 * Table memory for the page walker: word array, prompt or slow acks.
 * Assumes mem_addr and mem_write stay put while mem_req waits for ack.
 */
`timescale 1ns/10ps
module tlpt_mem_model
(
    // bus from the walker
    input  wire logic        mclk,
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    // pacing
    input  wire logic        slow,
    // answer
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [31:0] mem [0:4095];
    int          wait_n = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    always @(posedge mclk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;  // stale data is inverted on every cycle
        if (mem_req && !mem_ack && wait_n < (slow ? 3 : 0))
            wait_n <= wait_n + 1;
        else if (mem_req && !mem_ack)
        begin
            wait_n    <= 0;
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr[13:2]];
            if (mem_write)
                mem[mem_addr[13:2]] <= mem_wdata;
        end
    end
endmodule

/* test/tb.sv */
/*
 * Self-checking bench for the page translation unit with table memory.
 * Assumes tables at 0x1000 (directory), 0x2000 and 0x3000, and a page frame at 0x9000.
 */
`timescale 1ns/10ps
module tb;
    logic        mclk, reset, reg_wr_en, reg_sel, tr_on, wp, req_valid;
    logic        req_ready, req_write, resp_valid, resp_fault, cdis, wt;
    logic        mem_req, mem_write, mem_ack, mem_nc, slow, dir_nc, cach;
    logic [1:0]  reg_cpl, req_cpl, kind;
    logic [2:0]  code;
    logic [31:0] reg_wdata, flt_q, base_q, lin, phys, maddr, mwd, mrd;
    int          err_total = 0;
    int          checks = 0;
    tlpt_unit i_dut (.mclk(mclk), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_cpl(reg_cpl),
        .fault_address_reg(flt_q), .directory_base_reg(base_q),
        .translation_on(tr_on), .write_protect(wp),
        .global_cache_off(1'b0), .external_cache_enable_in_n(1'b0),
        .req_valid(req_valid), .req_ready(req_ready), .req_lin_addr(lin),
        .req_write(req_write), .req_cpl(req_cpl), .req_kind(kind),
        .resp_valid(resp_valid), .resp_phys_addr(phys),
        .resp_fault(resp_fault), .resp_fault_code(code),
        .resp_cacheable(cach), .cache_disable_flag(cdis),
        .write_through_flag(wt), .mem_req(mem_req), .mem_write(mem_write),
        .mem_lock(), .mem_addr(maddr), .mem_wdata(mwd),
        .mem_nocache(mem_nc), .mem_wthru(), .mem_ack(mem_ack),
        .mem_rdata(mrd));
    tlpt_mem_model i_mem (.mclk(mclk), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(maddr), .mem_wdata(mwd),
        .slow(slow), .mem_ack(mem_ack), .mem_rdata(mrd));
    // ==========================================
    // clock, watchdog, walk observer
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        err_total++;
        end_of_test();
    end
    always @(posedge mclk)
        if (mem_req && !mem_write && maddr[31:12] == 20'h1)
            dir_nc = mem_nc;
    // ==========================================
    // tasks
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wreg(logic [1:0] cpl, logic [31:0] d);
        reg_wr_en = 1'b1;
        reg_sel = 1'b1;
        reg_cpl = cpl;
        reg_wdata = d;
        @(posedge mclk);
        #1 reg_wr_en = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic xl(logic [31:0] a, logic w, logic [1:0] cpl, logic f,
                      logic [2:0] c, logic [31:0] p);
        int n;
        n = 0;
        req_valid = 1'b1;
        lin = a;
        req_write = w;
        req_cpl = cpl;
        @(posedge mclk);
        #1 req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 200)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk("resp", resp_valid, 1);
        chk("fault", resp_fault, f);
        if (f)
            chk("code", code, c);
        else
            chk("phys", phys, p);
        @(posedge mclk);
        #1;
    endtask
    task automatic end_of_test;
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // scenarios
    initial
    begin
        {reg_wr_en, reg_sel, tr_on, wp, req_valid, req_write, slow} = 0;
        {reg_cpl, req_cpl, kind, reg_wdata, lin} = 0;
        reset = 1'b1;
        repeat (8) @(posedge mclk);
        #1 reset = 1'b0;
        chk("base", base_q, 0);
        wreg(2'h1, 32'hFFFF_FFFF);
        chk("base", base_q, 0);
        wreg(2'h0, 32'hFFFF_FFFF);
        chk("base", base_q, 32'hFFFF_F018);
        wreg(2'h0, 32'h0000_1010);
        i_mem.mem[12'h401] = 32'h0000_2007;
        i_mem.mem[12'h802] = 32'h0005_6E0F;
        i_mem.mem[12'h402] = 32'h0000_3025;
        i_mem.mem[12'hC00] = 32'h0000_906F;
        i_mem.mem[12'h403] = 32'h0;
        tr_on = 1'b1;
        xl(32'h0040_2345, 1, 3, 0, 0, 32'h0005_6345);
        chk("dir", i_mem.mem[12'h401], 32'h0000_2027);
        chk("tbl", i_mem.mem[12'h802], 32'h0005_6E6F);
        chk("dir_nc", dir_nc, 1);
        chk("wt", {cdis, wt}, 2'h1);
        chk("cach", cach, 1);
        slow = 1'b1;
        i_mem.mem[12'h802] = 32'h0007_7E7F;
        wreg(2'h0, 32'h0000_1010);
        xl(32'h0040_2345, 0, 0, 0, 0, 32'h0007_7345);
        chk("pins", {cdis, wt}, 2'h3);
        chk("cach", cach, 0);
        slow = 1'b0;
        kind = 2'h1;
        xl(32'h0040_2345, 0, 0, 0, 0, 32'h0040_2345);
        chk("pins", {cdis, wt}, 2'h0);
        kind = 2'h0;
        xl(32'h0080_0004, 1, 3, 1, 3'h7, 0);
        chk("flt", flt_q, 32'h0080_0004);
        wp = 1'b1;
        xl(32'h0080_0008, 1, 0, 1, 3'h3, 0);
        chk("flt", flt_q, 32'h0080_0008);
        wp = 1'b0;
        xl(32'h0080_0008, 1, 1, 0, 0, 32'h0000_9008);
        tr_on = 1'b0;
        xl(32'h1234_5678, 0, 0, 0, 0, 32'h1234_5678);
        chk("pins", {cdis, wt}, 2'h0);
        tr_on = 1'b1;
        xl(32'h00C0_0010, 0, 2, 1, 3'h0, 0);
        end_of_test();
    end
endmodule
